//--- adc_acquisition_averager.sv
// ADC acquisition averager: reference sync, acquisition gate, channel sequencing and
// averaging of the last samples of each switching period.
// Assumes the converter returns a sample per sync pulse before the next pulse.
`timescale 1ns/1ns
`include "adc_avg_consts.svh"

module adc_acquisition_averager (
  input wire logic i_clk_sys, // 50 MHz system clock
  input wire logic i_reset_n, // Synchronous reset, active low
  input wire logic [7:0] i_addr, // Register address
  input wire logic [31:0] i_wdata, // Register write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after strobe
  input wire logic [15:0] i_adc_data, // Converter sample, two's complement
  output logic o_sync_pulse_out, // Reference sync pulse; sample at rising edge
  output logic o_acq_gate, // Acquisition gate
  output logic [7:0] o_channel, // Physical channel to the switch
  output logic [15:0] o_result, // Averaged result
  output logic [7:0] o_result_chan, // Physical channel of the result
  output logic o_result_valid // One-cycle result strobe
);

  // Control registers
  logic run_r;
  logic [7:0] ref_div_r;
  logic [7:0] switch_cycle_count_r;
  logic [15:0] gap_r;
  logic [4:0] tlen_r;
  logic [7:0] tab_chan [0:`TABLE_DEPTH-1];
  logic [7:0] tab_avg [0:`TABLE_DEPTH-1];
  logic [31:0] rdata_r;

  // Sequencer state
  adc_avg_pkg::acq_state_t state_r;
  logic [7:0] ref_cnt_r;
  logic [7:0] sw_cnt_r;
  logic [15:0] gap_cnt_r;
  logic gap_wait_r;
  logic [`TABLE_AW-1:0] idx_r;
  logic [7:0] tcnt_r;
  logic sampling_r;
  logic [`ACC_W-1:0] acc_r;
  logic [15:0] result_r;
  logic [7:0] result_chan_r;
  logic result_valid_r;
  logic sync_r;
  logic [7:0] chan_r;

  // Decode
  wire wr_ctrl = i_wr && (i_addr == `ADDR_CTRL);
  wire wr_div = i_wr && (i_addr == `ADDR_REF_DIV);
  wire wr_sw = i_wr && (i_addr == `ADDR_SWITCH);
  wire wr_gap = i_wr && (i_addr == `ADDR_GAP);
  wire wr_tlen = i_wr && (i_addr == `ADDR_TLEN);
  wire in_table = (i_addr[7:4] == 4'(`ADDR_TABLE_BASE >> 4));
  wire wr_tab = i_wr && in_table;
  wire [`TABLE_AW-1:0] tsel = i_addr[`TABLE_AW-1:0];

  // Reference timing: one edge per ref_div cycles; pulse spans SYNC_HIGH_CYC cycles
  wire ref_tick = (ref_cnt_r == 8'h00);
  wire [7:0] cur_avg = tab_avg[idx_r];
  wire [7:0] cur_settle = switch_cycle_count_r - cur_avg;
  wire in_tail = (sw_cnt_r >= cur_settle);
  wire last_of_period = (sw_cnt_r == switch_cycle_count_r - 8'h01);
  wire last_entry = ({1'b0, idx_r} == tlen_r - 5'h01);
  // Entry that just closed; the index has already moved on when its mean is formed
  wire [`TABLE_AW-1:0] prev_idx = (idx_r == '0) ? `TABLE_AW'(tlen_r - 5'h01) : idx_r - `TABLE_AW'(1);
  wire edge_now = ref_tick && !gap_wait_r && (state_r == adc_avg_pkg::ST_RUN);
  // Gate is raised in ST_SETUP at least GATE_SETUP_CYC cycles plus one reference period before the first edge
  wire [7:0] setup_lead = 8'(`GATE_SETUP_CYC);
  wire [7:0] hold_len = 8'(`GATE_HOLD_CYC);

  // Read mux: unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (i_addr == `ADDR_CTRL)
      rd_mux = {31'h0, run_r};
    else if (i_addr == `ADDR_REF_DIV)
      rd_mux = {24'h0, ref_div_r};
    else if (i_addr == `ADDR_SWITCH)
      rd_mux = {24'h0, switch_cycle_count_r};
    else if (i_addr == `ADDR_GAP)
      rd_mux = {16'h0, gap_r};
    else if (i_addr == `ADDR_TLEN)
      rd_mux = {27'h0, tlen_r};
    else if (i_addr == `ADDR_STATUS)
      rd_mux = {24'h0, idx_r, state_r};
    else if (in_table)
      rd_mux = {16'h0, tab_avg[tsel], tab_chan[tsel]};
  end

  // Register writes; entry factors default to one and are clamped to 1..128
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      run_r <= 1'b0;
      ref_div_r <= `REF_DIV_DEFAULT;
      switch_cycle_count_r <= `SWITCH_CYC_DEFAULT;
      gap_r <= 16'h0;
      tlen_r <= 5'h01;
      rdata_r <= 32'h0;
      for (int k = 0; k < `TABLE_DEPTH; k++)
      begin
        tab_chan[k] <= 8'(k);
        tab_avg[k] <= `AVG_FACTOR_DEFAULT;
      end
    end
    else
    begin
      if (i_rd)
        rdata_r <= rd_mux;
      if (wr_ctrl)
        run_r <= i_wdata[`CTRL_RUN_BIT];
      if (wr_div && i_wdata[7:0] > 8'h03)
        ref_div_r <= i_wdata[7:0];
      if (wr_sw && i_wdata[7:0] != 8'h00)
        switch_cycle_count_r <= i_wdata[7:0];
      if (wr_gap)
        gap_r <= i_wdata[15:0];
      if (wr_tlen && i_wdata[4:0] != 5'h00 && i_wdata[4:0] <= 5'(`TABLE_DEPTH))
        tlen_r <= i_wdata[4:0];
      if (wr_tab)
      begin
        tab_chan[tsel] <= i_wdata[7:0];
        if (i_wdata[15:8] == 8'h00)
          tab_avg[tsel] <= 8'h01;
        else if (i_wdata[15:8] > `AVG_FACTOR_MAX)
          tab_avg[tsel] <= `AVG_FACTOR_MAX;
        else
          tab_avg[tsel] <= i_wdata[15:8];
      end
    end
  end

  // Acquisition state: setup lead, run, hold after the last edge
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      state_r <= adc_avg_pkg::ST_IDLE;
      tcnt_r <= 8'h0;
    end
    else
    begin
      case (state_r)
        adc_avg_pkg::ST_IDLE:
          if (run_r)
          begin
            state_r <= adc_avg_pkg::ST_SETUP;
            tcnt_r <= 8'h0;
          end
        adc_avg_pkg::ST_SETUP:
          if (ref_tick && tcnt_r >= setup_lead)
            state_r <= adc_avg_pkg::ST_RUN;
          else if (tcnt_r != 8'hff)
            tcnt_r <= tcnt_r + 8'h01;
        adc_avg_pkg::ST_RUN:
          if (!run_r && edge_now)
          begin
            state_r <= adc_avg_pkg::ST_HOLD;
            tcnt_r <= 8'h0;
          end
        adc_avg_pkg::ST_HOLD:
          if (tcnt_r >= hold_len)
            state_r <= adc_avg_pkg::ST_IDLE;
          else
            tcnt_r <= tcnt_r + 8'h01;
        default:
          state_r <= adc_avg_pkg::ST_IDLE;
      endcase
    end
  end

  // Reference divider runs freely; gap counter stretches the first entry
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      ref_cnt_r <= 8'h0;
      sync_r <= 1'b0;
    end
    else
    begin
      ref_cnt_r <= ref_tick ? ref_div_r - 8'h01 : ref_cnt_r - 8'h01;
      if (edge_now)
        sync_r <= 1'b1;
      else if (ref_cnt_r == ref_div_r - 8'(`SYNC_HIGH_CYC))
        sync_r <= 1'b0;
    end
  end

  // Channel sequencing and averaging; sample taken two clocks after each tail pulse rises
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
    begin
      sw_cnt_r <= 8'h0;
      idx_r <= '0;
      gap_cnt_r <= 16'h0;
      gap_wait_r <= 1'b0;
      sampling_r <= 1'b0;
      acc_r <= '0;
      result_r <= 16'h0;
      result_chan_r <= 8'h0;
      result_valid_r <= 1'b0;
    end
    else
    begin
      result_valid_r <= 1'b0;
      if (state_r == adc_avg_pkg::ST_IDLE)
      begin
        sw_cnt_r <= 8'h0;
        idx_r <= '0;
        acc_r <= '0;
        gap_wait_r <= (gap_r != 16'h0);
        gap_cnt_r <= gap_r;
      end
      else if (gap_wait_r && ref_tick && state_r == adc_avg_pkg::ST_RUN)
      begin
        // Gap counted in whole reference periods, so every later edge stays on the reference grid
        gap_cnt_r <= gap_cnt_r - 16'h1;
        if (gap_cnt_r == 16'h1)
          gap_wait_r <= 1'b0;
      end
      else if (edge_now)
      begin
        sampling_r <= in_tail;
        if (last_of_period)
        begin
          sw_cnt_r <= 8'h0;
          if (last_entry)
          begin
            idx_r <= '0;
            gap_wait_r <= (gap_r != 16'h0);
            gap_cnt_r <= gap_r;
          end
          else
            idx_r <= idx_r + `TABLE_AW'(1);
        end
        else
          sw_cnt_r <= sw_cnt_r + 8'h01;
      end
      // The tail sample of an entry is read two cycles after its edge
      if (sampling_r && ref_cnt_r == ref_div_r - 8'h02)
      begin
        sampling_r <= 1'b0;
        if (sw_cnt_r == 8'h0)
        begin
          // Entry closed: index already advanced, so use the previous one
          result_r <= avg_div(acc_r + `ACC_W'(signed'(i_adc_data)), tab_avg[prev_idx]);
          result_chan_r <= tab_chan[prev_idx];
          result_valid_r <= 1'b1;
          acc_r <= '0;
        end
        else
          acc_r <= acc_r + `ACC_W'(signed'(i_adc_data));
      end
    end
  end

  // Switch position lags the index by one cycle, so the converter still sees
  // the entry's own channel at the sync edge on which the index moves on
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      chan_r <= 8'h0;
    else
      chan_r <= tab_chan[idx_r];
  end

  // Signed division by the factor; a divider is costly but factors are arbitrary 1..128
  function automatic logic [15:0] avg_div(input logic [`ACC_W-1:0] sum, input logic [7:0] n);
    logic signed [`ACC_W-1:0] q;
    q = signed'(sum) / signed'({16'h0, n});
    return q[15:0];
  endfunction

  assign o_rdata = rdata_r;
  assign o_sync_pulse_out = sync_r;
  assign o_acq_gate = (state_r != adc_avg_pkg::ST_IDLE);
  assign o_channel = chan_r;
  assign o_result = result_r;
  assign o_result_chan = result_chan_r;
  assign o_result_valid = result_valid_r;

endmodule

//--- adc_avg_consts.svh
// Timing counts, table layout and reset values for the ADC acquisition averager.
// Assumes a 50 MHz system clock; included by its bare name.
`ifndef ADC_AVG_CONSTS_SVH
`define ADC_AVG_CONSTS_SVH

`define CLK_PERIOD_NS 20
`define SYNC_HIGH_NS 50
`define SYNC_HIGH_CYC ((`SYNC_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GATE_SETUP_NS 45
`define GATE_SETUP_CYC ((`GATE_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GATE_HOLD_NS 150
`define GATE_HOLD_CYC ((`GATE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_DIV_DEFAULT 8'h19
`define SWITCH_CYC_DEFAULT 8'h01
`define AVG_FACTOR_MAX 8'h80
`define AVG_FACTOR_DEFAULT 8'h01
`define TABLE_DEPTH 16
`define TABLE_AW 4
`define ACC_W 24
`define SAMPLE_W 16

`define ADDR_CTRL 8'h00
`define ADDR_REF_DIV 8'h01
`define ADDR_SWITCH 8'h02
`define ADDR_GAP 8'h03
`define ADDR_TLEN 8'h04
`define ADDR_STATUS 8'h05
`define ADDR_TABLE_BASE 8'h10

`define CTRL_RUN_BIT 0

`endif

//--- adc_avg_pkg.sv
// Types for the ADC acquisition averager.
// Used with adc_avg_consts.svh.
package adc_avg_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HOLD = 4'b1000
  } acq_state_t;
endpackage

//--- adc_avg_props.sv
// Checker for the ADC acquisition averager: sync, gate and result timing.
// Bound to the top module from the testbench; sees only its ports.
`timescale 1ns/1ns
`include "adc_avg_consts.svh"
module adc_avg_props (
  input wire logic i_clk_sys, // Clock
  input wire logic i_reset_n, // Reset, active low
  input wire logic [7:0] i_addr, // Address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [31:0] o_rdata, // Read data
  input wire logic [15:0] i_adc_data, // Sample
  input wire logic o_sync_pulse_out, // Sync
  input wire logic o_acq_gate, // Gate
  input wire logic [7:0] o_channel, // Channel
  input wire logic [15:0] o_result, // Result
  input wire logic [7:0] o_result_chan, // Result channel
  input wire logic o_result_valid // Result strobe
);
  logic [7:0] ref_r; // Divider as accepted by the block
  logic [7:0] since_r; // Cycles since sync rise, ff when idle
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);
  // Mirror divider writes; small values are refused by the block
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n)
      ref_r <= `REF_DIV_DEFAULT;
    else if (i_wr && i_addr == `ADDR_REF_DIV && i_wdata[7:0] > 8'h03)
      ref_r <= i_wdata[7:0];
  end
  // Saturating age of the last sync edge, held at ff while the gate is low
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_reset_n || !o_acq_gate)
      since_r <= 8'hff;
    else if ($rose(o_sync_pulse_out))
      since_r <= 8'h01;
    else if (since_r != 8'hff)
      since_r <= since_r + 8'h01;
  end
  property p_sync_width;
    $rose(o_sync_pulse_out) |-> o_sync_pulse_out [*3] ##1 !o_sync_pulse_out;
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync width wrong");
  property p_sync_gap;
    $rose(o_sync_pulse_out) |=> !$rose(o_sync_pulse_out) [*3];
  endproperty
  a_sync_gap: assert property (p_sync_gap) else $error("sync edges too close");
  // Gap periods keep edges on the reference grid
  property p_sync_grid;
    $rose(o_sync_pulse_out) && since_r != 8'hff |-> (since_r % ref_r) == 8'h00;
  endproperty
  a_sync_grid: assert property (p_sync_grid) else $error("sync off grid");
  property p_gate_setup;
    $rose(o_sync_pulse_out) |-> $past(o_acq_gate, 3);
  endproperty
  a_gate_setup: assert property (p_gate_setup) else $error("gate setup short");
  property p_gate_hold;
    $fell(o_acq_gate) |-> since_r >= 8'h08;
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate hold short");
  property p_sync_in_gate;
    $rose(o_sync_pulse_out) |-> o_acq_gate;
  endproperty
  a_sync_in_gate: assert property (p_sync_in_gate) else $error("sync outside gate");
  property p_valid_pulse;
    o_result_valid |=> !o_result_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("result strobe long");
  property p_valid_after;
    o_result_valid |-> o_acq_gate && since_r >= 8'h01 && since_r <= 8'h03;
  endproperty
  a_valid_after: assert property (p_valid_after) else $error("result strobe late");
  c_sync: cover property ($rose(o_sync_pulse_out));
  c_result: cover property (o_result_valid);
  c_stop: cover property ($fell(o_acq_gate));
endmodule

//--- adc_chip_model.sv
// Converter and switch model: converts the selected channel at each sync edge.
// Assumes the block reads the sample two clocks after the sync rising edge.
`timescale 1ns/1ns
module adc_chip_model (
  input wire logic i_clk_sys, // Clock
  input wire logic i_sync, // Sync from the block
  input wire logic [7:0] i_channel, // Switch position
  output logic [15:0] o_sample // Converter output
);
  logic flip_r; // Alternates low bits so means land on a half
  initial
  begin
    flip_r = 1'b0;
    o_sample = 16'h5a5a;
  end
  // Convert at the sync edge, once the channel has settled
  always @(posedge i_sync)
  begin
    #1;
    flip_r = ~flip_r;
    o_sample <= {i_channel, 8'h00} + (flip_r ? 16'h0003 : 16'h0000);
  end
  // Output is not held after the pulse, so it is scrambled
  always @(negedge i_clk_sys)
  begin
    if (!i_sync)
      o_sample <= ~o_sample;
  end
endmodule

//--- testbench.sv
// Testbench for the ADC acquisition averager: registers, runs and averaging.
// Assumes the converter model answers every sync pulse.
`timescale 1ns/1ns
module testbench;
  logic i_clk_sys;
  logic i_reset_n;
  logic [7:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic [15:0] i_adc_data;
  logic o_sync_pulse_out;
  logic o_acq_gate;
  logic [7:0] o_channel;
  logic [15:0] o_result;
  logic [7:0] o_result_chan;
  logic o_result_valid;
  int fails;
  int n_checks;
  int cyc;
  int t_res; // Cycle of the last result strobe
  int span; // Cycles between the last two result strobes
  adc_acquisition_averager adc_acquisition_averager_inst (.i_clk_sys, .i_reset_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_adc_data, .o_sync_pulse_out, .o_acq_gate,
    .o_channel, .o_result, .o_result_chan, .o_result_valid);
  adc_chip_model adc_chip_model_inst (.i_clk_sys(i_clk_sys), .i_sync(o_sync_pulse_out),
    .i_channel(o_channel), .o_sample(i_adc_data));
  // 50 MHz clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(name, o_rdata, exp);
  endtask
  // Waits on falling edges so the one-cycle strobe is seen settled
  task automatic res(input logic [7:0] ch, input logic [15:0] v);
    int k;
    k = 0;
    @(negedge i_clk_sys);
    while (o_result_valid !== 1'b1 && k < 500)
    begin
      @(negedge i_clk_sys);
      k++;
    end
    chk("result_valid", {31'h0, o_result_valid}, 32'h1);
    span = cyc - t_res;
    t_res = cyc;
    chk("result_chan", {24'h0, o_result_chan}, {24'h0, ch});
    chk("result", {16'h0, o_result}, {16'h0, v});
  endtask
  task automatic stop_run();
    int k;
    k = 0;
    wr(8'h00, 32'h0);
    while (o_acq_gate !== 1'b0 && k < 200)
    begin
      @(negedge i_clk_sys);
      k++;
    end
    chk("gate", {31'h0, o_acq_gate}, 32'h0);
  endtask
  // A hang counts as a mismatch
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      end_sim();
    end
  end
  initial
  begin
    fails = 0;
    n_checks = 0;
    cyc = 0;
    t_res = 0;
    span = 0;
    i_reset_n = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    rd(8'h05, 32'h01, "status");
    rd(8'h01, 32'h19, "ref_div");
    rd(8'h02, 32'h01, "switch");
    rd(8'h08, 32'h0, "unmapped");
    for (int i = 0; i < 16; i++)
      rd(8'h10 + 8'(i), {16'h0, 8'h01, 8'(i)}, "entry");
    // Defaults give single raw samples; first conversion carries the odd offset
    wr(8'h00, 32'h1);
    res(8'h00, 16'h0003);
    res(8'h00, 16'h0000);
    stop_run();
    wr(8'h01, 32'h3);
    rd(8'h01, 32'h19, "ref_div_refused");
    wr(8'h10, 32'h0003);
    rd(8'h10, 32'h0103, "factor_zero");
    wr(8'h10, 32'hc803);
    rd(8'h10, 32'h8003, "factor_clamp");
    // Unequal factors, settle samples, gap; means truncate toward zero
    wr(8'h01, 32'h8);
    wr(8'h02, 32'h4);
    wr(8'h03, 32'h1);
    wr(8'h04, 32'h2);
    wr(8'h10, 32'h0203);
    wr(8'h11, 32'h0490);
    wr(8'h00, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      res(8'h03, 16'h0301);
      // Four reference periods of 8 cycles plus one gap period across the frame edge
      if (i > 0)
        chk("frame_spacing", span, 32'h28);
      res(8'h90, 16'h9002);
      chk("entry_spacing", span, 32'h20);
    end
    stop_run();
    end_sim();
  end
endmodule
bind adc_acquisition_averager adc_avg_props adc_avg_props_inst (.i_clk_sys, .i_reset_n,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_adc_data, .o_sync_pulse_out, .o_acq_gate,
  .o_channel, .o_result, .o_result_chan, .o_result_valid);
